// >>> design/ldc_cfg_regs.sv
// Configuration registers of the first serial port and the wake control unit, on APB.
//
// How it works
// (RL1) Serial mode register resets to 02h.
// (RL2) Mode bit 7 enables port bank switching.
// (RL3) Mode bit 2 reads live port busy.
// (RL4) Low power while active: clock off, defaults.
// (RL5) Ring indication still interrupts in low power.
// (RL6) Low power keeps registers; inactive blocks access.
// (RL7) Normal power while active enables port clock.
// (RL8) Bit 0 plus inactive: outputs high impedance.
// (RL9) Wake activate clear blocks unit registers; 00h.
// (RL10) Inactive wake unit keeps values, detection runs.
// (RL11) Wake base high: read-write, resets 00h.
// (RL12) Wake base low bits 4-0 read zero.
// (RL13) Wake interrupt type: only bit 1 writable, 03h.
// (RL14) Both DMA reports read 04h always.
// (RL15) Serial mode bits 6-3 read zero.
//
// Chosen here: the APB interface to the registers.
`include "ldc_defines.svh"

module ldc_cfg_regs
  import ldc_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  input  wire logic [3:0]      pstrb,
  output logic                 pready,
  output logic [31:0]          prdata,
  output logic                 pslverr,
  input  wire logic            sp_busy,
  input  wire logic            ring_indication_input,
  input  wire logic            sp_ring_irq_en,
  output ldc_serial_ctl_s      sp_ctl,
  output ldc_wake_cfg_s        wk_cfg
);

  ldc_state_s q;
  ldc_state_s d;
  ldc_sel_e   sel;

  // Reset words are held at full width so that single fields can be picked out by position.
  localparam logic [7:0] ACT_RST   = `LDC_ACTIVATE_RST;
  localparam logic [7:0] MODE_RST  = `LDC_SERIAL_MODE_RST;
  localparam logic [7:0] BLOW_RST  = `LDC_BASE_LOW_RST;
  localparam logic [7:0] ITYPE_RST = `LDC_IRQ_TYPE_RST;

  function automatic logic [11:0] reg_addr(input logic [11:0] base, input logic [7:0] idx);
    reg_addr = base | {2'b00, idx, 2'b00};
  endfunction

  function automatic ldc_sel_e decode(input logic [11:0] a);
    decode = LDC_SEL_NONE;
    if (a == reg_addr(`LDC_SERIAL_BASE, `LDC_IDX_ACTIVATE)) begin
      decode = LDC_SEL_SP_ACTIVATE;
    end else if (a == reg_addr(`LDC_SERIAL_BASE, `LDC_IDX_SERIAL_MODE)) begin
      decode = LDC_SEL_SP_MODE;
    end else if (a == reg_addr(`LDC_WAKE_BASE, `LDC_IDX_ACTIVATE)) begin
      decode = LDC_SEL_WK_ACTIVATE;
    end else if (a == reg_addr(`LDC_WAKE_BASE, `LDC_IDX_BASE_HIGH)) begin
      decode = LDC_SEL_WK_BASE_HIGH;
    end else if (a == reg_addr(`LDC_WAKE_BASE, `LDC_IDX_BASE_LOW)) begin
      decode = LDC_SEL_WK_BASE_LOW;
    end else if (a == reg_addr(`LDC_WAKE_BASE, `LDC_IDX_IRQ_NUMBER)) begin
      decode = LDC_SEL_WK_IRQ_NUMBER;
    end else if (a == reg_addr(`LDC_WAKE_BASE, `LDC_IDX_IRQ_TYPE)) begin
      decode = LDC_SEL_WK_IRQ_TYPE;
    end else if (a == reg_addr(`LDC_WAKE_BASE, `LDC_IDX_DMA_A)) begin
      decode = LDC_SEL_WK_DMA_A;
    end else if (a == reg_addr(`LDC_WAKE_BASE, `LDC_IDX_DMA_B)) begin
      decode = LDC_SEL_WK_DMA_B;
    end
  endfunction

  function automatic logic [7:0] mode_value(input ldc_state_s s, input logic busy);
    mode_value = 8'h00;
    // (RL15) Reserved bits zero
    mode_value[`LDC_MODE_BANK_BIT]  = s.sp_bank_en;
    // (RL3) Live busy readback
    mode_value[`LDC_MODE_BUSY_BIT]  = busy;
    mode_value[`LDC_MODE_POWER_BIT] = s.sp_power_normal;
    mode_value[`LDC_MODE_HIZ_BIT]   = s.sp_hiz_en;
  endfunction

  function automatic logic [7:0] irq_type_value(input ldc_state_s s);
    // (RL13) Fixed bits from reset
    irq_type_value = `LDC_IRQ_TYPE_RST;
    irq_type_value[`LDC_IRQ_TYPE_RW_BIT] = s.wk_irq_type_rw;
  endfunction

  function automatic logic [7:0] base_low_value(input ldc_state_s s);
    // (RL12) Low address bits zero
    base_low_value = {s.wk_base_low, `LDC_BASE_LOW_RO_LSBS'(0)};
  endfunction

  function automatic logic [7:0] read_value(input ldc_sel_e s_sel, input ldc_state_s s,
                                            input logic busy);
    read_value = 8'h00;
    case (s_sel)
      LDC_SEL_SP_ACTIVATE:   read_value = {7'h00, s.sp_active};
      LDC_SEL_SP_MODE:       read_value = mode_value(s, busy);
      LDC_SEL_WK_ACTIVATE:   read_value = {7'h00, s.wk_active};
      LDC_SEL_WK_BASE_HIGH:  read_value = s.wk_base_high;
      LDC_SEL_WK_BASE_LOW:   read_value = base_low_value(s);
      LDC_SEL_WK_IRQ_NUMBER: read_value = s.wk_irq_number;
      LDC_SEL_WK_IRQ_TYPE:   read_value = irq_type_value(s);
      // (RL14) Fixed no-DMA report
      LDC_SEL_WK_DMA_A:      read_value = `LDC_NO_DMA_VALUE;
      LDC_SEL_WK_DMA_B:      read_value = `LDC_NO_DMA_VALUE;
      default:               read_value = 8'h00;
    endcase
  endfunction

  always_comb begin
    d   = q;
    sel = decode(paddr);

    // One wait state lets read data come straight from a flip-flop, at the
    // cost of a three-cycle transfer.
    case (q.phase)
      LDC_PH_SETUP: begin
        if (psel && penable) begin
          d.phase = LDC_PH_ANSWER;
          d.rdata = {24'h00_0000, read_value(sel, q, sp_busy)};
          d.err   = (sel == LDC_SEL_NONE);
        end
      end
      LDC_PH_ANSWER: begin
        d.phase = LDC_PH_SETUP;
        d.err   = 1'b0;
        if (psel && penable && pwrite && pstrb[0]) begin
          case (sel)
            // (RL6) Serial port activate
            LDC_SEL_SP_ACTIVATE: d.sp_active = pwdata[`LDC_ACTIVATE_BIT];
            LDC_SEL_SP_MODE: begin
              // (RL2) Bank switch bit
              d.sp_bank_en      = pwdata[`LDC_MODE_BANK_BIT];
              d.sp_power_normal = pwdata[`LDC_MODE_POWER_BIT];
              d.sp_hiz_en       = pwdata[`LDC_MODE_HIZ_BIT];
            end
            // (RL9) Wake unit activate
            LDC_SEL_WK_ACTIVATE:   d.wk_active = pwdata[`LDC_ACTIVATE_BIT];
            // (RL11) Base high write
            LDC_SEL_WK_BASE_HIGH:  d.wk_base_high = pwdata[7:0];
            LDC_SEL_WK_BASE_LOW:   d.wk_base_low = pwdata[7:`LDC_BASE_LOW_RO_LSBS];
            LDC_SEL_WK_IRQ_NUMBER: d.wk_irq_number = pwdata[7:0];
            // (RL13) Only bit 1 stored
            LDC_SEL_WK_IRQ_TYPE:   d.wk_irq_type_rw = pwdata[`LDC_IRQ_TYPE_RW_BIT];
            default: begin
            end
          endcase
        end
      end
      default: d.phase = LDC_PH_SETUP;
    endcase

    // (RL7) Clock on in normal power
    d.sp_ctl.clk_en         = q.sp_active && q.sp_power_normal;
    // (RL4) Low power forces defaults
    d.sp_ctl.force_default  = q.sp_active && !q.sp_power_normal;
    // (RL8) Idle outputs high impedance
    d.sp_ctl.output_hiz     = !q.sp_active && q.sp_hiz_en;
    d.sp_ctl.bank_switch_en = q.sp_bank_en;
    // (RL6) Access follows activate only
    d.sp_ctl.port_access_en = q.sp_active;
    // (RL5) Ring path ignores power mode
    d.sp_ctl.ring_irq       = q.sp_active && sp_ring_irq_en && ring_indication_input;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.phase           <= LDC_PH_SETUP;
      q.rdata           <= 32'h0000_0000;
      q.err             <= 1'b0;
      q.sp_active       <= ACT_RST[`LDC_ACTIVATE_BIT];
      // (RL1) Mode register reset value
      q.sp_bank_en      <= MODE_RST[`LDC_MODE_BANK_BIT];
      q.sp_power_normal <= MODE_RST[`LDC_MODE_POWER_BIT];
      q.sp_hiz_en       <= MODE_RST[`LDC_MODE_HIZ_BIT];
      // (RL9) Wake activate resets clear
      q.wk_active       <= ACT_RST[`LDC_ACTIVATE_BIT];
      q.wk_base_high    <= `LDC_BASE_HIGH_RST;
      q.wk_base_low     <= BLOW_RST[7:`LDC_BASE_LOW_RO_LSBS];
      q.wk_irq_number   <= `LDC_IRQ_NUMBER_RST;
      q.wk_irq_type_rw  <= ITYPE_RST[`LDC_IRQ_TYPE_RW_BIT];
      q.sp_ctl          <= '0;
    end else begin
      q <= d;
    end
  end

  assign pready  = (q.phase == LDC_PH_ANSWER);
  assign prdata  = q.rdata;
  assign pslverr = pready && q.err;
  assign sp_ctl  = q.sp_ctl;

  // (RL10) Deactivation gates access only; stored values and detection stay live.
  assign wk_cfg = {q.wk_active, q.wk_base_high, base_low_value(q), q.wk_irq_number,
                   irq_type_value(q)};

endmodule

// >>> design/ldc_defines.svh
// Offsets, field positions, reset values and constants of the configuration registers.
`ifndef LDC_DEFINES_SVH
`define LDC_DEFINES_SVH

// Each logical device has its own block of configuration words on the bus.
// The byte address of a register is its block base plus four times its index.
`define LDC_SERIAL_BASE      12'h000
`define LDC_WAKE_BASE        12'h400

// Register indices within a logical device.
`define LDC_IDX_ACTIVATE     8'h30
`define LDC_IDX_BASE_HIGH    8'h60
`define LDC_IDX_BASE_LOW     8'h61
`define LDC_IDX_IRQ_NUMBER   8'h70
`define LDC_IDX_IRQ_TYPE     8'h71
`define LDC_IDX_DMA_A        8'h74
`define LDC_IDX_DMA_B        8'h75
`define LDC_IDX_SERIAL_MODE  8'hF0

// Reset values.
`define LDC_ACTIVATE_RST     8'h00
`define LDC_SERIAL_MODE_RST  8'h02
`define LDC_BASE_HIGH_RST    8'h00
`define LDC_BASE_LOW_RST     8'h00
`define LDC_IRQ_NUMBER_RST   8'h00
`define LDC_IRQ_TYPE_RST     8'h03
`define LDC_NO_DMA_VALUE     8'h04

// Field positions.
`define LDC_ACTIVATE_BIT     0
`define LDC_MODE_BANK_BIT    7
`define LDC_MODE_BUSY_BIT    2
`define LDC_MODE_POWER_BIT   1
`define LDC_MODE_HIZ_BIT     0
`define LDC_IRQ_TYPE_RW_BIT  1
`define LDC_BASE_LOW_RO_LSBS 5

`endif

// >>> design/ldc_pkg.sv
// Types shared by the logical device configuration registers.
package ldc_pkg;

  typedef enum logic {
    LDC_PH_SETUP,
    LDC_PH_ANSWER
  } ldc_phase_e;

  typedef enum logic [3:0] {
    LDC_SEL_NONE,
    LDC_SEL_SP_ACTIVATE,
    LDC_SEL_SP_MODE,
    LDC_SEL_WK_ACTIVATE,
    LDC_SEL_WK_BASE_HIGH,
    LDC_SEL_WK_BASE_LOW,
    LDC_SEL_WK_IRQ_NUMBER,
    LDC_SEL_WK_IRQ_TYPE,
    LDC_SEL_WK_DMA_A,
    LDC_SEL_WK_DMA_B
  } ldc_sel_e;

  // Controls that the configuration hands to the first serial port.
  typedef struct packed {
    logic clk_en;
    logic force_default;
    logic output_hiz;
    logic bank_switch_en;
    logic port_access_en;
    logic ring_irq;
  } ldc_serial_ctl_s;

  // Configuration that the wake control unit runs from.
  typedef struct packed {
    logic        access_en;
    logic [15:0] base_addr;
    logic [7:0]  irq_number;
    logic [7:0]  irq_type;
  } ldc_wake_cfg_s;

  typedef struct packed {
    ldc_phase_e      phase;
    logic [31:0]     rdata;
    logic            err;
    logic            sp_active;
    logic            sp_bank_en;
    logic            sp_power_normal;
    logic            sp_hiz_en;
    logic            wk_active;
    logic [7:0]      wk_base_high;
    logic [2:0]      wk_base_low;
    logic [7:0]      wk_irq_number;
    logic            wk_irq_type_rw;
    ldc_serial_ctl_s sp_ctl;
  } ldc_state_s;

endpackage

// >>> bench/ldc_cfg_regs_checker.sv
// Port-level assertions for the configuration register block.
module ldc_cfg_regs_checker
  import ldc_pkg::*;
(
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [11:0]     paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [3:0]      pstrb,
  input wire logic            pready,
  input wire logic [31:0]     prdata,
  input wire logic            pslverr,
  input wire logic            sp_busy,
  input wire logic            ring_indication_input,
  input wire logic            sp_ring_irq_en,
  input wire ldc_serial_ctl_s sp_ctl,
  input wire ldc_wake_cfg_s   wk_cfg
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_clk_force_excl: assert property (!(sp_ctl.clk_en && sp_ctl.force_default))
    else $error("port clock and forced defaults together");
  chk_clk_needs_act: assert property (sp_ctl.clk_en |-> sp_ctl.port_access_en)
    else $error("port clock while inactive");
  chk_hiz_inactive: assert property (sp_ctl.output_hiz |-> !sp_ctl.port_access_en)
    else $error("high impedance while active");
  chk_ring_cause: assert property (sp_ctl.ring_irq |-> $past(ring_indication_input) && $past(sp_ring_irq_en))
    else $error("ring interrupt without cause");
  chk_type_fixed: assert property (wk_cfg.irq_type[7:2] == 6'h00 && wk_cfg.irq_type[0])
    else $error("fixed interrupt type bits wrong");
  chk_base_align: assert property (wk_cfg.base_addr[4:0] == 5'h00)
    else $error("wake base not aligned");
  chk_ready_wait: assert property ($rose(penable) && psel |=> pready ##1 !pready)
    else $error("answer not one cycle after access");
  chk_err_ready: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error without answer or with data");
  chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read lanes not zero");
  chk_dma_fixed: assert property (pready && !pwrite && (paddr == 12'h5d0 || paddr == 12'h5d4) |-> prdata == 32'h0000_0004)
    else $error("no-DMA report not 04h");
  chk_mode_reserved: assert property (pready && !pwrite && paddr == 12'h3c0 |-> prdata[6:3] == 4'h0)
    else $error("reserved mode bits not zero");
  cover property (sp_ctl.clk_en);
  cover property (sp_ctl.force_default);
  cover property (sp_ctl.output_hiz);
  cover property (pslverr);
endmodule

bind ldc_cfg_regs ldc_cfg_regs_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .sp_busy, .ring_indication_input,
  .sp_ring_irq_en, .sp_ctl, .wk_cfg);

// >>> bench/tb_logical_device_config_regs.sv
// Self-checking bench of the configuration registers against a reference model.
module tb_logical_device_config_regs
  import ldc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] AD [9] = '{12'h0c0, 12'h3c0, 12'h4c0, 12'h580, 12'h584, 12'h5c0,
                                     12'h5c4, 12'h5d0, 12'h5d4};
  localparam logic [7:0] RS [9] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h04, 8'h04};
  localparam logic [7:0] WM [9] = '{8'h01, 8'h83, 8'h01, 8'hff, 8'he0, 8'hff, 8'h02, 8'h00, 8'h00};
  localparam logic [7:0] FX [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h04, 8'h04};
  logic            pclk = 1'b0;
  logic            presetn = 1'b0;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [11:0]     paddr = 12'h000;
  logic [31:0]     pwdata = 32'h0000_0000;
  logic [3:0]      pstrb = 4'h0;
  logic            sp_busy = 1'b0;
  logic            ring_indication_input = 1'b0;
  logic            sp_ring_irq_en = 1'b0;
  logic            pready;
  logic            pslverr;
  logic            er;
  logic [31:0]     prdata;
  logic [31:0]     rd;
  logic [31:0]     d;
  logic [31:0]     r2;
  logic [3:0]      st;
  logic [7:0]      mem [9];
  ldc_serial_ctl_s sp_ctl;
  ldc_wake_cfg_s   wk_cfg;
  int              i;
  int              j;
  int              k;
  int              n_fail = 0;
  int              compares = 0;

  always #4 pclk = ~pclk;

  ldc_cfg_regs i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .prdata, .pslverr, .sp_busy, .ring_indication_input, .sp_ring_irq_en, .sp_ctl,
    .wk_cfg);

  task automatic chk(string nm, logic [39:0] e, logic [39:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // The answer is taken at the rising edge where pready is seen high; one idle edge follows,
  // so that back-to-back calls never drive psel twice in one time step.
  task automatic apb(bit w, logic [11:0] a, logic [31:0] wd, logic [3:0] s,
                     output logic [31:0] r, output logic e);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      final_report();
    end
    @(posedge pclk);
  endtask

  task automatic outs();
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("sp_ctl", {mem[0][0] & mem[1][1], mem[0][0] & ~mem[1][1], ~mem[0][0] & mem[1][0],
        mem[1][7], mem[0][0], mem[0][0] & sp_ring_irq_en & ring_indication_input}, sp_ctl);
    chk("wk_cfg", {mem[2][0], mem[3], mem[4][7:5], 5'h00, mem[5], mem[6]}, wk_cfg);
    @(posedge pclk);
  endtask

  initial begin
    void'($urandom(32'h793d));
    // The second pass resets in mid-run, after the first pass's 80 random writes to randomly chosen registers.
    for (k = 0; k < 2; k++) begin
      presetn <= 1'b0;
      sp_busy <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (i = 0; i < 9; i++) begin
        mem[i] = RS[i];
        apb(1'b0, AD[i], 32'h0000_0000, 4'hf, rd, er);
        chk("reset value", {32'h0000_0000, RS[i]}, rd);
      end
      outs();
      $display("test reset values done");
      repeat (80) begin
        i = $urandom_range(0, 8);
        d = $urandom;
        r2 = $urandom;
        st = r2[3:0] | 4'h6;
        sp_busy <= r2[4];
        ring_indication_input <= r2[5];
        sp_ring_irq_en <= r2[6];
        apb(1'b1, AD[i], d, st, rd, er);
        chk("write error", 40'h0, er);
        if (st[0]) mem[i] = (d[7:0] & WM[i]) | FX[i];
        outs();
        j = $urandom_range(0, 8);
        apb(1'b0, AD[j], 32'h0000_0000, 4'hf, rd, er);
        chk("read value", mem[j] | {5'h00, j == 1 && sp_busy, 2'h0}, rd);
      end
      $display("test random access done");
    end
    apb(1'b0, 12'h100, 32'h0000_0000, 4'hf, rd, er);
    chk("unmapped error", 40'h1, er);
    chk("unmapped data", 40'h0, rd);
    $display("test unmapped done");
    final_report();
  end
endmodule
